// file: include/mfid_pkg.sv
/*
 * constants for the status flag word and maker identification word of a
 * four-channel power monitor register map.
 * assumes an upstream serial front end that hands over one register access
 * at a time as address plus read or write strobe on the system clock.
 */
//
// Contract
// - four energy overflow bits at 11:8
// - ready flag set when cycle fully done
// - config write clears ready, power-down write not
// - flag read clears ready, returns old value
// - results readable anytime, last completed cycle
// - math overflow bit 6 marks invalid results
// - fixed maker code word at 7Eh
// - three limit bits at 14:12, reset zero
package mfid_pkg;

  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned NUM_CH      = 4;
  localparam int unsigned NUM_LIMITS  = 3;

  localparam logic [ADDR_W-1:0] CONFIG_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] FLAGS_ADDR  = 8'h0b;
  localparam logic [ADDR_W-1:0] MAKER_ADDR  = 8'h7e;

  localparam int unsigned LIMIT_LO_BIT = 12;
  localparam int unsigned CH_OVF_LO_BIT = 8;
  localparam int unsigned READY_BIT    = 7;
  localparam int unsigned MATH_OVF_BIT = 6;
  localparam int unsigned RSVD_W       = 6;

  localparam int unsigned MODE_LO_BIT  = 0;
  localparam int unsigned MODE_W       = 3;
  localparam logic [MODE_W-1:0] MODE_POWER_DOWN = 3'h0;

  localparam logic [DATA_W-1:0] FLAGS_RST  = 16'h0000;
  localparam logic [DATA_W-1:0] RDATA_RST  = 16'h0000;
  localparam logic [DATA_W-1:0] UNMAPPED_RDATA = 16'h0000;
  localparam logic [RSVD_W-1:0] RSVD_VALUE = 6'h00;

  // arbitrary neutral value, replaced per product
  localparam logic [DATA_W-1:0] MAKER_CODE_DEFAULT = 16'h4d43;

endpackage

// file: src/mfid_flags_regs.sv
/*
 * status flag word and maker identification word of the monitor.
 * assumes the serial front end, sequencer, math unit, accumulators and
 * limit comparators all run on clk_sys_i, so no input is synchronised;
 * at most one of reg_rd_i or reg_wr_i is high in a cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module mfid_flags_regs
  import mfid_pkg::*;
#(
  parameter logic [DATA_W-1:0] MAKER_CODE = MAKER_CODE_DEFAULT
) (
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_i,
  input  wire logic [ADDR_W-1:0]     reg_addr_i,
  input  wire logic                  reg_rd_i,
  input  wire logic                  reg_wr_i,
  input  wire logic [DATA_W-1:0]     reg_wdata_i,
  input  wire logic                  conv_done_i,
  input  wire logic                  math_ovf_i,
  input  wire logic [NUM_CH-1:0]     accum_overflow_i,
  input  wire logic [NUM_LIMITS-1:0] limit_exceeded_i,
  output logic      [DATA_W-1:0]     reg_rdata_o,
  output logic                       reg_rvalid_o,
  output logic                       result_ready_flag_o
);

  logic                  result_ready_flag_q;
  logic                  math_overflow_flag_q;
  logic [NUM_CH-1:0]     accum_overflow_q;
  logic [NUM_LIMITS-1:0] limit_exceeded_q;
  logic [DATA_W-1:0]     rdata_q;
  logic                  rvalid_q;
  logic [DATA_W-1:0]     flags_word;
  logic                  flags_rd;
  logic                  cfg_wr;
  logic                  cfg_wr_pd;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] target);
    hit = (a == target);
  endfunction

  // power-down is told apart by the mode field alone; the other config
  // fields of that write belong to other blocks and do not matter here
  assign flags_rd  = reg_rd_i && hit(reg_addr_i, FLAGS_ADDR);
  assign cfg_wr    = reg_wr_i && hit(reg_addr_i, CONFIG_ADDR);
  assign cfg_wr_pd = cfg_wr &&
    (reg_wdata_i[MODE_LO_BIT +: MODE_W] == MODE_POWER_DOWN);

  always_comb begin
    flags_word = FLAGS_RST;
    flags_word[LIMIT_LO_BIT +: NUM_LIMITS] = limit_exceeded_q;
    flags_word[CH_OVF_LO_BIT +: NUM_CH]    = accum_overflow_q;
    flags_word[READY_BIT]    = result_ready_flag_q;
    flags_word[MATH_OVF_BIT] = math_overflow_flag_q;
    flags_word[RSVD_W-1:0]   = RSVD_VALUE;
  end

  // a completed cycle in the same edge as a clear wins, so no ready
  // event is lost between the host's read and the next cycle
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      result_ready_flag_q <= 1'b0;
    end else if (conv_done_i) begin
      result_ready_flag_q <= 1'b1;
    end else if (flags_rd) begin
      result_ready_flag_q <= 1'b0;
    end else if (cfg_wr && !cfg_wr_pd) begin
      result_ready_flag_q <= 1'b0;
    end
  end

  // overflow and limit bits mirror their sources; the sources own the
  // stickiness, so this block never clears them on its own
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      math_overflow_flag_q <= 1'b0;
      accum_overflow_q     <= '0;
      limit_exceeded_q     <= '0;
    end else begin
      math_overflow_flag_q <= math_ovf_i;
      accum_overflow_q     <= accum_overflow_i;
      limit_exceeded_q     <= limit_exceeded_i;
    end
  end

  // reads are never held off: result registers elsewhere answer at any
  // time, and this word is captured before the ready clear takes effect
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_q  <= RDATA_RST;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd_i;
      if (reg_rd_i) begin
        if (hit(reg_addr_i, FLAGS_ADDR)) begin
          rdata_q <= flags_word;
        end else if (hit(reg_addr_i, MAKER_ADDR)) begin
          rdata_q <= MAKER_CODE;
        end else begin
          rdata_q <= UNMAPPED_RDATA;
        end
      end
    end
  end

  assign reg_rdata_o         = rdata_q;
  assign reg_rvalid_o        = rvalid_q;
  assign result_ready_flag_o = result_ready_flag_q;

  // checks sample strobes and outputs on the same edge the logic uses, so a
  // read's answer is always looked at one edge after the strobe
  sequence s_flags_read;
    reg_rd_i && hit(reg_addr_i, FLAGS_ADDR);
  endsequence

  sequence s_answer;
    ##1 reg_rvalid_o;
  endsequence

  ready_set_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    conv_done_i |=> result_ready_flag_o)
    else $error("ready flag not set after completed cycle");

  ready_no_spurious_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    $rose(result_ready_flag_o) |-> $past(conv_done_i))
    else $error("ready flag rose without completed cycle");

  ready_cfg_clr_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (cfg_wr && !cfg_wr_pd && !conv_done_i) |=> !result_ready_flag_o)
    else $error("config write did not clear ready flag");

  ready_pd_keep_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (cfg_wr_pd && !conv_done_i) |=> $stable(result_ready_flag_o))
    else $error("power-down write changed ready flag");

  ready_rd_clr_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (s_flags_read and !conv_done_i) |=> !result_ready_flag_o)
    else $error("flag read did not clear ready flag");

  read_old_ready_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    s_flags_read |=>
      (reg_rdata_o[READY_BIT] == $past(result_ready_flag_o)))
    else $error("flag read did not return pre-clear ready value");

  read_answer_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    reg_rd_i |-> s_answer)
    else $error("read got no answer in one cycle");

  energy_ovf_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    s_flags_read ##0 $past(accum_overflow_i) != '0 |=>
      (reg_rdata_o[CH_OVF_LO_BIT +: NUM_CH] == $past(accum_overflow_i, 2)))
    else $error("energy overflow bits wrong in flag word");

  math_ovf_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    math_ovf_i ##1 s_flags_read |=> reg_rdata_o[MATH_OVF_BIT])
    else $error("math overflow not reported");

  maker_word_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (reg_rd_i && hit(reg_addr_i, MAKER_ADDR)) |=>
      (reg_rdata_o == MAKER_CODE))
    else $error("maker code word wrong");

  limit_bits_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    s_flags_read |=> (reg_rdata_o[LIMIT_LO_BIT +: NUM_LIMITS] ==
      $past(limit_exceeded_i, 2)))
    else $error("limit bits wrong in flag word");

  reserved_zero_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    s_flags_read |=> (reg_rdata_o[RSVD_W-1:0] == RSVD_VALUE))
    else $error("reserved flag bits not zero");

  // no disable here: this check is about reset itself, including a reset
  // that arrives while the flag is set
  reset_values_a: assert property (
    @(posedge clk_sys_i)
    rst_i |=> (reg_rdata_o == RDATA_RST && !reg_rvalid_o &&
      !result_ready_flag_o))
    else $error("outputs not at reset values after reset");

  // the ready flag moves only on a finished cycle or one of the two clears;
  // anything else would make the host's polling unreliable
  ready_hold_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (!conv_done_i && !flags_rd && !(cfg_wr && !cfg_wr_pd)) |=>
      $stable(result_ready_flag_o))
    else $error("ready flag changed without a cause");

  // a clear never swallows a finished cycle
  ready_set_wins_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (conv_done_i && (flags_rd || cfg_wr)) |=> result_ready_flag_o)
    else $error("clear beat a completed cycle in the same edge");

  // read data stands until the next read so a slow front end can shift it
  rdata_hold_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    !reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");

  rvalid_only_read_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    !reg_rd_i |=> !reg_rvalid_o)
    else $error("read answer without a read");

endmodule

`default_nettype wire

// file: verification/mfid_src_model.sv
/*
 * source model for sequencer, math unit, accumulators and limits.
 * assumes the bench raises fire_i at a falling edge, for one cycle or longer.
 */
`timescale 1ns/1ps
`default_nettype none
module mfid_src_model (
  input  wire logic       clk_sys_i,
  input  wire logic       fire_i,
  input  wire logic [7:0] lvl_i,
  output logic            conv_done_o,
  output logic            math_ovf_o,
  output logic [3:0]      accum_o,
  output logic [2:0]      limit_o
);
  logic fire_q = 1'b0;
  initial conv_done_o = 1'b0;
  // edge detect: a held request must not look like many finished cycles
  always @(negedge clk_sys_i) begin
    conv_done_o <= fire_i & ~fire_q;
    fire_q <= fire_i;
  end
  assign accum_o    = lvl_i[3:0];
  assign limit_o    = lvl_i[6:4];
  assign math_ovf_o = lvl_i[7];
endmodule
`default_nettype wire

// file: verification/mfid_flags_regs_tb.sv
/*
 * bench for the flag word and maker identification word.
 * assumes the source model feeds the sequencer and overflow inputs.
 */
`timescale 1ns/1ps
`default_nettype none
module mfid_flags_regs_tb;
  import mfid_pkg::*;
  logic              clk_sys_i = 1'b0;
  logic              rst_i = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic              rd = 1'b0;
  logic              wr = 1'b0;
  logic [DATA_W-1:0] wdata = '0;
  logic              fire = 1'b0;
  logic [7:0]        lvl = '0;
  logic              done, movf, rvalid, rdy;
  logic [3:0]        acc;
  logic [2:0]        lim;
  logic [DATA_W-1:0] rdata;
  int                num_errors = 0;
  int                n_compared = 0;
  always #10 clk_sys_i = ~clk_sys_i;
  mfid_src_model mfid_src_model_inst (.clk_sys_i(clk_sys_i),
    .fire_i(fire), .lvl_i(lvl), .conv_done_o(done),
    .math_ovf_o(movf), .accum_o(acc), .limit_o(lim));
  mfid_flags_regs mfid_flags_regs_inst (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .reg_addr_i(addr), .reg_rd_i(rd), .reg_wr_i(wr),
    .reg_wdata_i(wdata), .conv_done_i(done), .math_ovf_i(movf),
    .accum_overflow_i(acc), .limit_exceeded_i(lim),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .result_ready_flag_o(rdy));
  task automatic cmp(input string what, input logic [15:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic rd_word(input logic [7:0] a, input logic [15:0] exp);
    @(negedge clk_sys_i);
    addr = a;
    rd = 1'b1;
    @(negedge clk_sys_i);
    rd = 1'b0;
    cmp("rvalid", 16'h0001, {15'h0, rvalid});
    cmp("rdata", exp, rdata);
  endtask
  task automatic wr_word(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_sys_i);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk_sys_i);
    wr = 1'b0;
  endtask
  task automatic pulse_done();
    @(negedge clk_sys_i);
    fire <= 1'b1;
    @(negedge clk_sys_i);
    fire <= 1'b0;
    repeat (2) @(negedge clk_sys_i);
  endtask
  task automatic test_done();
    if (num_errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clk_sys_i);
    rst_i = 1'b0;
    rd_word(FLAGS_ADDR, FLAGS_RST);
    rd_word(MAKER_ADDR, MAKER_CODE_DEFAULT);
    wr_word(MAKER_ADDR, 16'h0000);
    rd_word(MAKER_ADDR, MAKER_CODE_DEFAULT);
    lvl = 8'hd5;
    repeat (2) @(negedge clk_sys_i);
    rd_word(FLAGS_ADDR, 16'h5540);
    wr_word(FLAGS_ADDR, 16'hffff);
    rd_word(FLAGS_ADDR, 16'h5540);
    lvl = 8'h00;
    pulse_done();
    rd_word(FLAGS_ADDR, 16'h0080);
    cmp("ready", 16'h0000, {15'h0, rdy});
    rd_word(FLAGS_ADDR, 16'h0000);
    pulse_done();
    wr_word(CONFIG_ADDR, 16'h0000);
    cmp("ready", 16'h0001, {15'h0, rdy});
    wr_word(CONFIG_ADDR, 16'h0007);
    cmp("ready", 16'h0000, {15'h0, rdy});
    fire <= 1'b1;
    rd_word(FLAGS_ADDR, 16'h0000);
    fire <= 1'b0;
    cmp("ready", 16'h0001, {15'h0, rdy});
    rd_word(8'h55, UNMAPPED_RDATA);
    rd_word(FLAGS_ADDR, 16'h0080);
    @(negedge clk_sys_i);
    cmp("rvalid", 16'h0000, {15'h0, rvalid});
    cmp("rdata", 16'h0080, rdata);
    pulse_done();
    lvl = 8'hd5;
    rst_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    cmp("rdata", RDATA_RST, rdata);
    cmp("rvalid", 16'h0000, {15'h0, rvalid});
    cmp("ready", 16'h0000, {15'h0, rdy});
    rst_i = 1'b0;
    rd_word(FLAGS_ADDR, 16'h5540);
    test_done();
  end
  // the sequence needs well under 100 cycles; this is a wide margin
  initial begin
    #20us;
    num_errors++;
    test_done();
  end
endmodule
`default_nettype wire
